// ===== rffe_bank_pkg.sv
// Constants, register map and state encoding shared by the front-end control slave.
package rffe_bank_pkg;

    // Register addresses on the serial link.
    localparam logic [7:0] HB_SEL_ADDR = 8'h00;
    localparam logic [7:0] LB_SEL_ADDR = 8'h01;
    localparam logic [7:0] STATUS_ADDR = 8'h1a;
    localparam logic [7:0] GROUP_ADDR = 8'h1b;

    // Reset values of the registers.
    localparam logic [7:0] HB_SEL_RST = 8'h00;
    localparam logic [7:0] LB_SEL_RST = 8'h00;
    localparam logic [6:0] FLAGS_RST = 7'h00;
    localparam logic [3:0] GROUP_SLAVE_IDENTIFIER_RST = 4'h0;
    localparam logic [3:0] GROUP_RSVD = 4'h0;
    localparam logic STATUS_TOP_RD = 1'b0;

    // Field layout of the status register.
    localparam int SOFT_RST_BIT = 7;
    localparam int CMD_PAR_BIT = 6;
    localparam int LEN_BIT = 5;
    localparam int ADDR_PAR_BIT = 4;
    localparam int DATA_PAR_BIT = 3;
    localparam int RD_BAD_BIT = 2;
    localparam int WR_BAD_BIT = 1;
    localparam int SHARED_ID_BIT = 0;
    localparam int FLAG_W = 7;

    // Widths of the switch-select field and the slave identifiers.
    localparam int SEL_W = 3;
    localparam int SID_W = 4;

    // Frame lengths, as the index of the last bit of each frame.
    localparam logic [3:0] CMD_LAST = 4'hc;
    localparam logic [3:0] FRAME_LAST = 4'h8;

    // Broadcast slave identifier and command field codes.
    localparam logic [3:0] BROADCAST_SID = 4'h0;
    localparam logic [2:0] CMD_REG_WR = 3'h2;
    localparam logic [2:0] CMD_REG_RD = 3'h3;
    localparam logic [3:0] CMD_EXT_WR = 4'h0;
    localparam logic [3:0] CMD_EXT_RD = 4'h2;

    // Link-side sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_WDATA,
        ST_WPARK,
        ST_RPARK,
        ST_RDATA,
        ST_REND
    } link_state_e;

endpackage : rffe_bank_pkg

// ===== pin_sync.sv
// Two flip-flop synchroniser for a group of independent pin levels.
module pin_sync #(
    parameter int WIDTH = 2 // Number of pin levels carried across.
) (
    input logic clock_i, // System clock.
    input logic sys_rst_i, // Synchronous reset, active high.
    input logic [WIDTH-1:0] async_i, // Levels straight from the pins.
    output logic [WIDTH-1:0] sync_o // Levels after two flip-flops.
);

    logic [WIDTH-1:0] meta_r; // First stage, read only by the second stage.
    logic [WIDTH-1:0] sync_r; // Second stage, safe for logic to read.

    // The first stage may go metastable, so only the second stage is exported.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule : pin_sync

// ===== rffe_slave_register_bank.sv
// Serial front-end control slave: link decoder and register bank of a dual antenna switch.
// What this block does
// - High-band select register lives at address 0x00.
// - Low-band select register lives at address 0x01.
// - Writing one to status bit 7 resets registers.
// - Software reset keeps the unique and group identifiers.
// - Bad command parity discards, flags bit 6; length flags 5.
// - Address frame parity error sets status bit 4.
// - Data frame parity error sets status bit 3.
// - Read of unimplemented address sets status bit 2.
// - Write to unimplemented address sets status bit 1.
// - Broadcast or group read sets status bit 0.
// - High-band select uses bits 2:0, zero isolates.
// - Low-band select uses bits 2:0, zero isolates.
module rffe_slave_register_bank #(
    parameter logic [rffe_bank_pkg::SID_W-1:0] UNIQUE_SLAVE_IDENTIFIER = 4'hb // Unique slave identifier.
) (
    input logic clock_i, // System clock, 125 MHz.
    input logic sys_rst_i, // Power-on reset, synchronous, active high.
    input logic sclk_i, // Link clock pin from the master.
    input logic sdata_i, // Link data pin, input side.
    output logic sdata_o, // Link data pin, output side.
    output logic sdata_oe_o, // Link data pin driven while high.
    output logic [rffe_bank_pkg::SEL_W-1:0] hb_select_o, // High-band throw code.
    output logic [rffe_bank_pkg::SEL_W-1:0] lb_select_o // Low-band throw code.
);
    import rffe_bank_pkg::*;

    // Odd parity check over a frame with its parity bit in the lowest place.
    function automatic logic odd_ok(input logic [12:0] w);
        return ^w;
    endfunction : odd_ok

    // True where a register answers at the given address.
    function automatic logic addr_valid(input logic [7:0] a);
        return (a == HB_SEL_ADDR) || (a == LB_SEL_ADDR) || (a == STATUS_ADDR) ||
               (a == GROUP_ADDR);
    endfunction : addr_valid

    // Read value of a register, zero where nothing is implemented.
    function automatic logic [7:0] reg_value(input logic [7:0] a, input logic [7:0] hb,
                                             input logic [7:0] lb, input logic [6:0] fl,
                                             input logic [3:0] gs);
        logic [7:0] v;
        v = 8'h00;
        if (a == HB_SEL_ADDR) begin
            v = hb;
        end else if (a == LB_SEL_ADDR) begin
            v = lb;
        end else if (a == STATUS_ADDR) begin
            v = {STATUS_TOP_RD, fl};
        end else if (a == GROUP_ADDR) begin
            v = {GROUP_RSVD, gs};
        end
        return v;
    endfunction : reg_value

    logic [1:0] pins_s; // Synchronised link clock and data.
    logic sclk_s; // Synchronised link clock.
    logic sdata_s; // Synchronised link data.
    logic sclk_d_r; // Link clock one cycle earlier.
    logic sdata_d_r; // Link data one cycle earlier.
    logic sclk_rise; // Link clock rising edge.
    logic sclk_fall; // Link clock falling edge.
    logic ssc_armed_r; // Data rose while the link clock was low.
    logic ssc; // Sequence start condition seen.
    link_state_e state_r; // Sequencer state.
    logic [11:0] shift_r; // Bits received so far in the frame.
    logic [12:0] frame_w; // Frame including the bit now sampled.
    logic [3:0] bit_cnt_r; // Index of the bit now expected.
    logic [7:0] addr_r; // Register address of the current access.
    logic [3:0] left_r; // Bytes still to move after the current one.
    logic rd_r; // Extended access is a read.
    logic owned_r; // Last sequence was ours and has ended.
    logic [8:0] tx_r; // Read byte and parity being sent.
    logic sdata_r; // Driven data level.
    logic sdata_oe_r; // Data pin drive enable.
    logic wr_stb_r; // One-cycle register write strobe.
    logic [7:0] wr_addr_r; // Address of the write.
    logic [7:0] wr_data_r; // Data of the write.
    logic [FLAG_W-1:0] err_set_r; // One-cycle error events.
    logic [7:0] hb_r; // High-band switch select register.
    logic [7:0] lb_r; // Low-band switch select register.
    logic [FLAG_W-1:0] flags_r; // Sticky error flags of the status register.
    logic [SID_W-1:0] group_slave_identifier_r; // Group slave identifier.
    logic soft_rst; // Software reset requested this cycle.
    logic cmd_done; // Last bit of a command frame sampled.
    logic frame_done; // Last bit of a nine-bit frame sampled.
    logic [3:0] cmd_sa; // Slave address of the command frame.
    logic [7:0] cmd_c; // Command field of the command frame.
    logic addressed; // Command is for this slave.
    logic rd_cmd; // Command is a read of either form.

    // Both pins cross into the system clock before anything looks at them.
    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .async_i({sclk_i, sdata_i}),
        .sync_o(pins_s)
    );

    assign sclk_s = pins_s[1];
    assign sdata_s = pins_s[0];
    assign sclk_rise = sclk_s && !sclk_d_r;
    assign sclk_fall = !sclk_s && sclk_d_r;
    assign frame_w = {shift_r, sdata_s};
    assign cmd_sa = frame_w[12:9];
    assign cmd_c = frame_w[8:1];
    assign addressed = (cmd_sa == UNIQUE_SLAVE_IDENTIFIER) || (cmd_sa == BROADCAST_SID) || (cmd_sa == group_slave_identifier_r);
    assign rd_cmd = (cmd_c[7:5] == CMD_REG_RD) || (cmd_c[7:4] == CMD_EXT_RD);
    assign cmd_done = (state_r == ST_CMD) && sclk_fall && (bit_cnt_r == CMD_LAST);
    assign frame_done = sclk_fall && (bit_cnt_r == FRAME_LAST);
    assign soft_rst = wr_stb_r && (wr_addr_r == STATUS_ADDR) && wr_data_r[SOFT_RST_BIT];

    // Edge history of the synchronised pins, and the start condition detector.
    // A start is a data pulse while the link clock stays low.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sclk_d_r <= 1'b0;
            sdata_d_r <= 1'b0;
            ssc_armed_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            sdata_d_r <= sdata_s;
            if (sclk_s) begin
                ssc_armed_r <= 1'b0;
            end else if (sdata_s && !sdata_d_r) begin
                ssc_armed_r <= 1'b1;
            end else if (!sdata_s && sdata_d_r) begin
                ssc_armed_r <= 1'b0;
            end
        end
    end

    assign ssc = ssc_armed_r && !sclk_s && !sdata_s && sdata_d_r;

    // Link sequencer: samples on falling edges, drives read data on rising edges.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            shift_r <= '0;
            bit_cnt_r <= '0;
            addr_r <= '0;
            left_r <= '0;
            rd_r <= 1'b0;
            owned_r <= 1'b0;
            tx_r <= '0;
            sdata_r <= 1'b0;
            sdata_oe_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
            err_set_r <= '0;
        end else begin
            wr_stb_r <= 1'b0;
            err_set_r <= '0;
            if (sclk_fall) begin
                shift_r <= frame_w[11:0];
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (ssc) begin
                // A start in the middle of a sequence means it was cut short.
                if (state_r != ST_IDLE) begin
                    err_set_r[LEN_BIT] <= 1'b1;
                end
                state_r <= ST_CMD;
                bit_cnt_r <= '0;
                owned_r <= 1'b0;
                sdata_oe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                        // Clock edges past the closing park make the sequence too long.
                        if (sclk_fall && owned_r) begin
                            err_set_r[LEN_BIT] <= 1'b1;
                            owned_r <= 1'b0;
                        end
                    end
                    ST_CMD: begin
                        if (cmd_done) begin
                            bit_cnt_r <= '0;
                            state_r <= ST_IDLE;
                            if (!odd_ok(frame_w)) begin
                                err_set_r[CMD_PAR_BIT] <= 1'b1;
                            end else if (!addressed) begin
                                state_r <= ST_IDLE;
                            end else if (rd_cmd && (cmd_sa != UNIQUE_SLAVE_IDENTIFIER)) begin
                                err_set_r[SHARED_ID_BIT] <= 1'b1;
                            end else if (cmd_c[7]) begin
                                // Short write of seven bits into the high-band select.
                                wr_stb_r <= 1'b1;
                                wr_addr_r <= HB_SEL_ADDR;
                                wr_data_r <= {1'b0, cmd_c[6:0]};
                                state_r <= ST_WPARK;
                            end else if (cmd_c[7:6] == CMD_REG_WR[2:1]) begin
                                addr_r <= {3'h0, cmd_c[4:0]};
                                left_r <= '0;
                                state_r <= cmd_c[5] ? ST_RPARK : ST_WDATA;
                            end else if ((cmd_c[7:4] == CMD_EXT_WR) || (cmd_c[7:4] == CMD_EXT_RD)) begin
                                left_r <= cmd_c[3:0];
                                rd_r <= cmd_c[5];
                                state_r <= ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (frame_done) begin
                            bit_cnt_r <= '0;
                            addr_r <= frame_w[8:1];
                            if (!odd_ok({4'h0, frame_w[8:0]})) begin
                                err_set_r[ADDR_PAR_BIT] <= 1'b1;
                                state_r <= ST_IDLE;
                            end else begin
                                state_r <= rd_r ? ST_RPARK : ST_WDATA;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (frame_done) begin
                            bit_cnt_r <= '0;
                            if (!odd_ok({4'h0, frame_w[8:0]})) begin
                                err_set_r[DATA_PAR_BIT] <= 1'b1;
                            end else begin
                                wr_stb_r <= 1'b1;
                                wr_addr_r <= addr_r;
                                wr_data_r <= frame_w[8:1];
                                err_set_r[WR_BAD_BIT] <= !addr_valid(addr_r);
                            end
                            addr_r <= addr_r + 8'h01;
                            left_r <= left_r - 4'h1;
                            if (left_r == 4'h0) begin
                                state_r <= ST_WPARK;
                            end
                        end
                    end
                    ST_WPARK: begin
                        // The bus park cycle closes a write sequence.
                        if (sclk_fall) begin
                            state_r <= ST_IDLE;
                            owned_r <= 1'b1;
                        end
                    end
                    ST_RPARK: begin
                        // Master releases the line during this park; load the first byte.
                        if (sclk_fall) begin
                            bit_cnt_r <= '0;
                            tx_r <= {reg_value(addr_r, hb_r, lb_r, flags_r, group_slave_identifier_r),
                                     ~^reg_value(addr_r, hb_r, lb_r, flags_r, group_slave_identifier_r)};
                            err_set_r[RD_BAD_BIT] <= !addr_valid(addr_r);
                            state_r <= ST_RDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (sclk_rise) begin
                            sdata_r <= tx_r[8];
                            sdata_oe_r <= 1'b1;
                            tx_r <= {tx_r[7:0], 1'b0};
                        end else if (frame_done) begin
                            bit_cnt_r <= '0;
                            addr_r <= addr_r + 8'h01;
                            left_r <= left_r - 4'h1;
                            if (left_r == 4'h0) begin
                                state_r <= ST_REND;
                            end else begin
                                tx_r <= {reg_value(addr_r + 8'h01, hb_r, lb_r, flags_r, group_slave_identifier_r),
                                         ~^reg_value(addr_r + 8'h01, hb_r, lb_r, flags_r, group_slave_identifier_r)};
                                err_set_r[RD_BAD_BIT] <= !addr_valid(addr_r + 8'h01);
                            end
                        end
                    end
                    ST_REND: begin
                        // Closing park: drive low for the high half, release on the fall.
                        if (sclk_rise) begin
                            sdata_r <= 1'b0;
                        end else if (sclk_fall) begin
                            sdata_oe_r <= 1'b0;
                            state_r <= ST_IDLE;
                            owned_r <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // High-band select register; the software reset returns it to isolation.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || soft_rst) begin
            hb_r <= HB_SEL_RST;
        end else if (wr_stb_r && (wr_addr_r == HB_SEL_ADDR)) begin
            hb_r <= wr_data_r;
        end
    end

    // Low-band select register; the software reset returns it to isolation.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || soft_rst) begin
            lb_r <= LB_SEL_RST;
        end else if (wr_stb_r && (wr_addr_r == LB_SEL_ADDR)) begin
            lb_r <= wr_data_r;
        end
    end

    // Group identifier survives the software reset; only power-on clears it.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            group_slave_identifier_r <= GROUP_SLAVE_IDENTIFIER_RST;
        end else if (wr_stb_r && (wr_addr_r == GROUP_ADDR)) begin
            group_slave_identifier_r <= wr_data_r[SID_W-1:0];
        end
    end

    // Sticky error flags; a new event wins over a simultaneous software reset.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= (soft_rst ? FLAGS_RST : flags_r) | err_set_r;
        end
    end

    assign sdata_o = sdata_r;
    assign sdata_oe_o = sdata_oe_r;
    assign hb_select_o = hb_r[SEL_W-1:0];
    assign lb_select_o = lb_r[SEL_W-1:0];

    default clocking dcb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence bad_cmd_s;
        cmd_done && !odd_ok(frame_w) && !ssc;
    endsequence

    sequence lands_idle_s;
        state_r == ST_IDLE && !wr_stb_r;
    endsequence

    hb_write_a: assert property (wr_stb_r && wr_addr_r == HB_SEL_ADDR |=> hb_r == $past(wr_data_r))
        else $error("high-band select did not take the written byte");
    lb_write_a: assert property (wr_stb_r && wr_addr_r == LB_SEL_ADDR |=> lb_r == $past(wr_data_r))
        else $error("low-band select did not take the written byte");
    soft_reset_a: assert property (soft_rst |=> hb_r == HB_SEL_RST && lb_r == LB_SEL_RST)
        else $error("software reset left a select register set");
    soft_keeps_a: assert property (soft_rst |=> $stable(group_slave_identifier_r))
        else $error("software reset changed the group identifier");
    cmd_parity_a: assert property (bad_cmd_s |=> lands_idle_s ##1 flags_r[CMD_PAR_BIT])
        else $error("command parity error not discarded or flagged");
    length_flag_a: assert property (ssc && state_r != ST_IDLE |=> ##1 flags_r[LEN_BIT])
        else $error("cut-short sequence not flagged");
    addr_parity_a: assert property (state_r == ST_ADDR && frame_done && !ssc &&
                                    !odd_ok({4'h0, frame_w[8:0]}) |=> ##1 flags_r[ADDR_PAR_BIT])
        else $error("address parity error not flagged");
    data_parity_a: assert property (state_r == ST_WDATA && frame_done && !ssc &&
                                    !odd_ok({4'h0, frame_w[8:0]}) |=> !wr_stb_r ##1 flags_r[DATA_PAR_BIT])
        else $error("data parity error wrote or went unflagged");
    read_bad_a: assert property (state_r == ST_RPARK && sclk_fall && !ssc && !addr_valid(addr_r)
                                 |=> ##1 flags_r[RD_BAD_BIT])
        else $error("read of empty address not flagged");
    write_bad_a: assert property (wr_stb_r && !addr_valid(wr_addr_r) |=> flags_r[WR_BAD_BIT])
        else $error("write to empty address not flagged");
    shared_read_a: assert property (cmd_done && !ssc && odd_ok(frame_w) && addressed && rd_cmd &&
                                    cmd_sa != UNIQUE_SLAVE_IDENTIFIER |=> state_r == ST_IDLE ##1 flags_r[SHARED_ID_BIT])
        else $error("shared identifier read not refused");
    flags_sticky_a: assert property (!soft_rst |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("an error flag cleared without a reset");

endmodule : rffe_slave_register_bank

// ===== link_master.sv
// Behavioural link master that frames sequences for the slave.
module link_master (
    input wire logic sdata_o, // Slave data output.
    input wire logic sdata_oe_o, // Slave drive enable.
    output logic sclk_o, // Link clock, still between sequences.
    output logic wire_o // Resolved data wire level.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic mval = 1'b0; // Master level; set high on release so stale data never lingers.
    assign wire_o = sdata_oe_o ? sdata_o : mval;
    initial sclk_o = 1'b0;
    // One bit: launched on the rise, taken by the slave on the fall.
    task automatic bit_out(input logic b);
        mval = b;
        sclk_o = 1'b1;
        #40;
        sclk_o = 1'b0;
        #40;
    endtask : bit_out
    // Start: data pulses high while the clock stays low.
    task automatic start_seq();
        mval = 1'b1;
        #40;
        mval = 1'b0;
        #40;
    endtask : start_seq
    // Frame of n bits MSB first plus odd parity, spoiled when bad is set.
    task automatic frame(input logic [11:0] v, input int n, input logic bad);
        logic p;
        p = ~^(v & ((12'h1 << n) - 12'h1)) ^ bad;
        for (int i = n - 1; i >= 0; i--) bit_out(v[i]);
        bit_out(p);
    endtask : frame
    // Read: park hands the line over, nine bits come back, closing park ends it.
    task automatic read_back(output logic [8:0] d);
        bit_out(1'b0);
        mval = 1'b1;
        for (int i = 8; i >= 0; i--) begin
            sclk_o = 1'b1;
            #40;
            d[i] = wire_o;
            sclk_o = 1'b0;
            #40;
        end
        // Closing park stays low: a high level once the slave lets go would look like a start.
        bit_out(1'b0);
    endtask : read_back
endmodule : link_master

// ===== rffe_slave_register_bank_bench.sv
// Self-checking bench for the switch slave register bank.
module rffe_slave_register_bank_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rffe_bank_pkg::*;
    localparam logic [3:0] SA = 4'hb; // Unique identifier given to the slave.
    logic clock_i = 1'b0, sys_rst_i = 1'b1, sclk, wl, sd, oe; // Clock, reset, link.
    logic [2:0] hb, lb; // Throw codes.
    logic [7:0] model [0:31]; // Register image; status flags kept at 0x1a.
    logic [8:0] rd; // Read byte with parity.
    logic [7:0] rv; // Random data.
    int failures = 0, check_count = 0;
    always #4 clock_i = ~clock_i;
    rffe_slave_register_bank rffe_slave_register_bank_i (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sdata_i(wl), .sdata_o(sd), .sdata_oe_o(oe),
        .hb_select_o(hb), .lb_select_o(lb));
    link_master link_master_i (.sdata_o(sd), .sdata_oe_o(oe), .sclk_o(sclk), .wire_o(wl));
    // Compares a throw code.
    task automatic chk_sel(input string n, input logic [2:0] e, input logic [2:0] g);
        check_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk_sel
    // Register write; the model follows the same sequence.
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic cb, input logic db);
        link_master_i.start_seq();
        link_master_i.frame({SA, 3'b010, a}, 12, cb);
        link_master_i.frame({4'h0, d}, 8, db);
        link_master_i.bit_out(1'b0);
        #200;
        if (cb) model[26][6] = 1'b1;
        else if (!(a inside {5'h00, 5'h01, 5'h1a, 5'h1b})) model[26][1] = 1'b1;
        else if (db) model[26][3] = 1'b1;
        else if (a == 5'h1a && d[7]) {model[0], model[1], model[26]} = '0;
        else if (a == 5'h1b) model[27] = {4'h0, d[3:0]};
        else if (a != 5'h1a) model[a] = d;
    endtask : wr
    // Register read; compares data and parity, or notes a refused shared read.
    task automatic rd_chk(input logic [3:0] s, input logic [4:0] a);
        logic [7:0] e;
        link_master_i.start_seq();
        link_master_i.frame({s, 3'b011, a}, 12, 1'b0);
        if (s != SA) begin
            link_master_i.bit_out(1'b0);
            model[26][0] = 1'b1;
        end else begin
            e = (a inside {5'h00, 5'h01, 5'h1a, 5'h1b}) ? model[a] : 8'h00;
            if (e == model[26]) e[7] = 1'b0;
            if (!(a inside {5'h00, 5'h01, 5'h1a, 5'h1b})) model[26][2] = 1'b1;
            link_master_i.read_back(rd);
            check_count++;
            if (rd !== {e, ~^e}) begin
                $display("ERROR read %h expected %h seen %h", a, {e, ~^e}, rd);
                failures++;
            end
        end
        #200;
    endtask : rd_chk
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hung handshake, about twice the length of all the tests.
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        foreach (model[i]) model[i] = 8'h00;
        void'($urandom(71382));
        repeat (16) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        #40;
        chk_sel("hb", 3'h0, hb);
        chk_sel("lb", 3'h0, lb);
        rd_chk(SA, GROUP_ADDR[4:0]);
        rd_chk(SA, STATUS_ADDR[4:0]);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            rv = 8'($urandom());
            rv[2:0] = i[2:0];
            wr(HB_SEL_ADDR[4:0], rv, 1'b0, 1'b0);
            chk_sel("hb", rv[2:0], hb);
            wr(LB_SEL_ADDR[4:0], ~rv, 1'b0, 1'b0);
            chk_sel("lb", ~rv[2:0], lb);
            rd_chk(SA, LB_SEL_ADDR[4:0]);
        end
        // Extended write of two bytes from the high-band select onwards.
        link_master_i.start_seq();
        link_master_i.frame({SA, CMD_EXT_WR, 4'h1}, 12, 1'b0);
        link_master_i.frame({4'h0, HB_SEL_ADDR}, 8, 1'b0);
        link_master_i.frame({4'h0, 8'h03}, 8, 1'b0);
        link_master_i.frame({4'h0, 8'h06}, 8, 1'b0);
        link_master_i.bit_out(1'b0);
        #200;
        {model[0], model[1]} = {8'h03, 8'h06};
        chk_sel("hb", model[0][2:0], hb);
        chk_sel("lb", model[1][2:0], lb);
        $display("select test done");
        wr(5'h00, 8'h05, 1'b1, 1'b0);
        chk_sel("hb", model[0][2:0], hb);
        wr(5'h01, 8'h02, 1'b0, 1'b1);
        chk_sel("lb", model[1][2:0], lb);
        link_master_i.start_seq();
        link_master_i.frame({SA, 8'h00}, 12, 1'b0);
        link_master_i.frame(12'h000, 8, 1'b1);
        link_master_i.bit_out(1'b0);
        model[26][4] = 1'b1;
        #200;
        // A write cut short by the next start is a length error.
        link_master_i.start_seq();
        link_master_i.frame({SA, 3'b010, 5'h01}, 12, 1'b0);
        model[26][5] = 1'b1;
        wr(5'h05, 8'h11, 1'b0, 1'b0);
        rd_chk(SA, 5'h05);
        rd_chk(BROADCAST_SID, 5'h01);
        rd_chk(SA, STATUS_ADDR[4:0]);
        $display("error test done");
        wr(GROUP_ADDR[4:0], 8'h35, 1'b0, 1'b0);
        rd_chk(SA, GROUP_ADDR[4:0]);
        // Short write addressed by the new group identifier.
        link_master_i.start_seq();
        link_master_i.frame({model[27][3:0], 1'b1, 7'h5d}, 12, 1'b0);
        link_master_i.bit_out(1'b0);
        #200;
        model[0] = 8'h5d;
        chk_sel("hb", model[0][2:0], hb);
        rd_chk(SA, HB_SEL_ADDR[4:0]);
        wr(STATUS_ADDR[4:0], 8'h80, 1'b0, 1'b0);
        chk_sel("hb", 3'h0, hb);
        chk_sel("lb", 3'h0, lb);
        rd_chk(SA, GROUP_ADDR[4:0]);
        rd_chk(SA, STATUS_ADDR[4:0]);
        $display("soft reset test done");
        tally_and_finish();
    end
endmodule : rffe_slave_register_bank_bench
